//--- isc_pkg.sv
// Shared constants for the two-wire command port and its bus master.
`default_nettype none
package isc_pkg;
  // ---------------------------------------------------------------
  // Clock and bus timing
  // ---------------------------------------------------------------
  localparam int CLK_FREQ_KHZ = 50000;
  localparam int BUS_FREQ_KHZ = 400;
  localparam int SCL_QTR_CYC  = (CLK_FREQ_KHZ + 4 * BUS_FREQ_KHZ - 1) / (4 * BUS_FREQ_KHZ);
  localparam int GLITCH_NS    = 50;
  localparam int FILT_CYC     = (GLITCH_NS * CLK_FREQ_KHZ + 999999) / 1000000;
  // ---------------------------------------------------------------
  // Frame and address
  // ---------------------------------------------------------------
  localparam int       BYTE_BITS  = 8;
  localparam logic [6:0] SLAVE_ADDR = 7'h64;
  localparam logic     RW_WRITE   = 1'b0;
  localparam logic     RW_READ    = 1'b1;
  localparam int       NUM_REGS   = 5;
  localparam logic [7:0] CMD_RESET  = 8'h00;
  localparam logic [7:0] IDLE_BYTE  = 8'hFF;
  localparam int       FIFO_DEPTH = 32;
  // ---------------------------------------------------------------
  // Master transaction steps, two bits per step, step 0 lowest
  // ---------------------------------------------------------------
  localparam logic [1:0] OP_START = 2'h0;
  localparam logic [1:0] OP_TX    = 2'h1;
  localparam logic [1:0] OP_RX    = 2'h2;
  localparam logic [1:0] OP_STOP  = 2'h3;
  localparam logic [9:0]  WR_OPS  = {OP_STOP, OP_TX, OP_TX, OP_TX, OP_START};
  localparam logic [13:0] RD_OPS  = {OP_STOP, OP_RX, OP_TX, OP_START, OP_TX, OP_TX, OP_START};
  localparam logic [2:0]  WR_LAST = 3'h4;
  localparam logic [2:0]  RD_LAST = 3'h6;
endpackage
`default_nettype wire

//--- isc_bus_if.sv
// Two-wire bus carrier joining the master end and the slave end.
`default_nettype none
interface isc_bus_if;
  logic sclMstOut;
  logic sclMstOe;
  logic sdaMstOut;
  logic sdaMstOe;
  logic sclSlvOut;
  logic sclSlvOe;
  logic sdaSlvOut;
  logic sdaSlvOe;
  logic scl;
  logic sda;
  // ---------------------------------------------------------------
  // Wired-AND lines with pull-ups
  // ---------------------------------------------------------------
  assign scl = (sclMstOe ? sclMstOut : 1'b1) & (sclSlvOe ? sclSlvOut : 1'b1);
  assign sda = (sdaMstOe ? sdaMstOut : 1'b1) & (sdaSlvOe ? sdaSlvOut : 1'b1);
  modport mst (input scl, input sda, output sclMstOut, output sclMstOe, output sdaMstOut, output sdaMstOe);
  modport slv (input scl, input sda, output sclSlvOut, output sclSlvOe, output sdaSlvOut, output sdaSlvOe);
endinterface
`default_nettype wire

//--- isc_fifo.sv
// Parameterised flip-flop FIFO with valid and ready on both sides.
`default_nettype none
module isc_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 32
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         inValid,
  output var  logic         inReady,
  input  wire logic [W-1:0] inData,
  output var  logic         outValid,
  input  wire logic         outReady,
  output var  logic [W-1:0] outData
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [DEPTH-1:0][W-1:0] mem_q;
  logic [PW-1:0]           wrPtr_q;
  logic [PW-1:0]           rdPtr_q;
  logic [CW-1:0]           cnt_q;
  logic [CW-1:0]           cnt_d;
  logic                    full_q;
  logic                    empty_q;
  wire                     doWr = inValid & ~full_q;
  wire                     doRd = outReady & ~empty_q;

  // ---------------------------------------------------------------
  // Occupancy and flags
  // ---------------------------------------------------------------
  assign cnt_d    = doWr & ~doRd ? cnt_q + CW'(1) : (doRd & ~doWr ? cnt_q - CW'(1) : cnt_q);
  assign inReady  = ~full_q;
  assign outValid = ~empty_q;
  assign outData  = mem_q[rdPtr_q];

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      cnt_q   <= '0;
      full_q  <= 1'b0;
      empty_q <= 1'b1;
    end else begin
      if (doWr) begin
        wrPtr_q <= (wrPtr_q == LAST_PTR) ? '0 : wrPtr_q + PW'(1);
      end
      if (doRd) begin
        rdPtr_q <= (rdPtr_q == LAST_PTR) ? '0 : rdPtr_q + PW'(1);
      end
      cnt_q   <= cnt_d;
      full_q  <= cnt_d == FULL_CNT;
      empty_q <= cnt_d == '0;
    end
  end

  always_ff @(posedge clk) begin
    if (doWr) begin
      mem_q[wrPtr_q] <= inData;
    end
  end
endmodule // isc_fifo
`default_nettype wire

//--- isc_master.sv
// Bus master end: queues commands and runs write or pointer-then-read transactions.
`default_nettype none
module isc_master
  import isc_pkg::*;
#(
  parameter int QTR_CYC = SCL_QTR_CYC,
  parameter int DEPTH   = FIFO_DEPTH
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  isc_bus_if.mst          bus,
  input  wire logic       cmdValid,
  output var  logic       cmdReady,
  input  wire logic       cmdRead,
  input  wire logic [7:0] cmdPtr,
  input  wire logic [7:0] cmdData,
  output var  logic       rdValid,
  output var  logic [7:0] rdData,
  output var  logic       ackErr,
  output var  logic       busy
);
  typedef enum logic [0:0] {M_IDLE = 1'b0, M_RUN = 1'b1} isc_mst_st_t;
  localparam int DW = $clog2(QTR_CYC);
  localparam logic [DW-1:0] DIV_LAST = DW'(QTR_CYC - 1);

  isc_mst_st_t   st_q;
  logic [DW-1:0] div_q;
  logic [2:0]    step_q;
  logic [1:0]    qtr_q;
  logic [3:0]    bit_q;
  logic [7:0]    rx_q;
  logic          read_q;
  logic [7:0]    ptr_q;
  logic [7:0]    data_q;
  logic          nack_q;
  logic          sda1_q;
  logic          sda2_q;
  logic          sclOe_q;
  logic          sdaOe_q;
  logic          rdValid_q;
  logic [7:0]    rdData_q;
  logic          ackErr_q;
  logic          busy_q;
  logic          fifoValid;
  logic [16:0]   fifoData;

  // ---------------------------------------------------------------
  // Command queue
  // ---------------------------------------------------------------
  wire pop = (st_q == M_IDLE) & fifoValid;
  isc_fifo #(.W(17), .DEPTH(DEPTH)) cmdFifo (
    .clk      (clk),
    .nrst     (nrst),
    .inValid  (cmdValid),
    .inReady  (cmdReady),
    .inData   ({cmdRead, cmdPtr, cmdData}),
    .outValid (fifoValid),
    .outReady (pop),
    .outData  (fifoData)
  );

  // ---------------------------------------------------------------
  // Step decode
  // ---------------------------------------------------------------
  wire       tick     = div_q == DIV_LAST;
  wire [1:0] op       = read_q ? RD_OPS[{step_q, 1'b0} +: 2] : WR_OPS[{step_q, 1'b0} +: 2];
  wire [2:0] lastStep = read_q ? RD_LAST : WR_LAST;
  wire [7:0] stepByte = (step_q == 3'h1) ? {SLAVE_ADDR, RW_WRITE} :
                        (step_q == 3'h2) ? ptr_q :
                        (step_q == 3'h3) ? data_q : {SLAVE_ADDR, RW_READ};
  wire       dataBit  = bit_q < 4'(BYTE_BITS);
  wire       bitTx    = stepByte[3'h7 - bit_q[2:0]];
  wire       byteOp   = (op == OP_TX) | (op == OP_RX);
  wire       opDone   = tick & (qtr_q == 2'h3) & (byteOp ? bit_q == 4'(BYTE_BITS) : 1'b1);
  wire       finish   = opDone & ((op == OP_STOP) | (step_q == lastStep));

  assign bus.sclMstOut = 1'b0;
  assign bus.sdaMstOut = 1'b0;
  assign bus.sclMstOe  = sclOe_q;
  assign bus.sdaMstOe  = sdaOe_q;
  assign rdValid       = rdValid_q;
  assign rdData        = rdData_q;
  assign ackErr        = ackErr_q;
  assign busy          = busy_q;

  // ---------------------------------------------------------------
  // Divider and line sampling
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      div_q  <= '0;
      sda1_q <= 1'b1;
      sda2_q <= 1'b1;
    end else begin
      div_q  <= tick ? '0 : div_q + DW'(1);
      sda1_q <= bus.sda;
      sda2_q <= sda1_q;
    end
  end

  // ---------------------------------------------------------------
  // Transaction engine
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q <= M_IDLE;
      step_q <= '0;
      qtr_q <= '0;
      bit_q <= '0;
      rx_q <= '0;
      read_q <= 1'b0;
      ptr_q <= '0;
      data_q <= '0;
      nack_q <= 1'b0;
      sclOe_q <= 1'b0;
      sdaOe_q <= 1'b0;
      rdValid_q <= 1'b0;
      rdData_q <= '0;
      ackErr_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      rdValid_q <= 1'b0;
      ackErr_q  <= 1'b0;
      if (pop) begin
        {read_q, ptr_q, data_q} <= fifoData;
        st_q   <= M_RUN;
        step_q <= '0;
        qtr_q  <= '0;
        bit_q  <= '0;
        nack_q <= 1'b0;
        busy_q <= 1'b1;
      end else if (st_q == M_RUN && tick) begin
        qtr_q <= qtr_q + 2'h1;
        unique case (op)
          OP_START: begin // see R04
            if (qtr_q == 2'h0) sdaOe_q <= 1'b0;
            if (qtr_q == 2'h1) sclOe_q <= 1'b0;
            if (qtr_q == 2'h2) sdaOe_q <= 1'b1;
            if (qtr_q == 2'h3) sclOe_q <= 1'b1;
          end
          OP_STOP: begin // see R05
            if (qtr_q == 2'h0) sdaOe_q <= 1'b1;
            if (qtr_q == 2'h1) sclOe_q <= 1'b0;
            if (qtr_q == 2'h2) sdaOe_q <= 1'b0; // see R02
          end
          OP_TX, OP_RX: begin // see R07, R10
            if (qtr_q == 2'h0) sdaOe_q <= (op == OP_TX) & dataBit & ~bitTx; // see R08, R09, R15
            if (qtr_q == 2'h1) sclOe_q <= 1'b0;
            if (qtr_q == 2'h2 && op == OP_TX && !dataBit) nack_q <= sda2_q;
            if (qtr_q == 2'h2 && op == OP_RX && dataBit) rx_q <= {rx_q[6:0], sda2_q}; // see R12
            if (qtr_q == 2'h3) begin
              sclOe_q <= 1'b1;
              bit_q   <= bit_q + 4'h1;
            end
          end
        endcase
        if (finish) begin
          st_q      <= M_IDLE;
          busy_q    <= 1'b0;
          rdValid_q <= read_q & ~nack_q;
          rdData_q  <= rx_q;
          ackErr_q  <= nack_q;
        end else if (opDone) begin
          bit_q  <= '0;
          step_q <= nack_q ? lastStep : step_q + 3'h1;
        end
      end
    end
  end
endmodule // isc_master
`default_nettype wire

//--- isc_slave.sv
// Slave end: filtered two-wire receiver with pointer, pending and active command bytes.
// Operation
// R01: Runs correctly at bus clocks up to 400kHz.
// R02: Master leaves both lines released when idle.
// R03: Clock and data inputs are glitch filtered.
// R04: Master opens each transaction with START, address.
// R05: Master ends each transaction with STOP.
// R06: STOP after writes puts new commands into effect.
// R07: Frames are eight bits plus acknowledge clock.
// R08: Master sends bytes most significant bit first.
// R09: Transmitter drives data bits, receiver drives acknowledge.
// R10: Master makes every clock edge, acknowledge included.
// R11: Device never pulls clock low, no stretching.
// R12: Read swaps roles after address; write keeps them.
// R13: Write address and each written byte acknowledged.
// R14: Read address acknowledged, then one byte sent.
// R15: Transmitter releases, receiver holds acknowledge low.
// R16: Device releases data after its eighth bit.
// R17: One byte per read; master answer ignored.
// R18: Fixed seven-bit address; next bit picks direction.
// R19: Odd bytes load pointer, even bytes pending data.
// R20: Extra read clocks see released line, ones.
// R21: STOP copies all pending data to active registers.
// R22: START mid-frame aborts byte, restarts address reception.
`default_nettype none
module isc_slave
  import isc_pkg::*;
#(
  parameter int NREG = NUM_REGS,
  parameter int FILT = FILT_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  isc_bus_if.slv                    bus,
  output var  logic [NREG-1:0][7:0] cmdRegs,
  output var  logic                 cmdApply
);
  typedef enum logic [2:0] {
    D_IDLE   = 3'b000,
    D_ADDR   = 3'b001,
    D_WRX    = 3'b010,
    D_ACK    = 3'b011,
    D_TX     = 3'b100,
    D_TXACK  = 3'b101,
    D_IGNORE = 3'b110,
    D_START  = 3'b111
  } isc_slv_st_t;
  localparam int IW = (NREG > 1) ? $clog2(NREG) : 1;
  localparam int FW = $clog2(FILT + 1);
  localparam logic [FW-1:0] FILT_LAST = FW'(FILT - 1);

  isc_slv_st_t          st_q;
  logic [2:0]           bitCnt_q;
  logic [7:0]           shift_q;
  logic [7:0]           tx_q;
  logic                 rw_q;
  logic                 addrAck_q;
  logic                 phase_q;
  logic [7:0]           ptr_q;
  logic [NREG-1:0][7:0] pend_q;
  logic [NREG-1:0][7:0] act_q;
  logic [NREG-1:0]      dirty_q;
  logic                 sdaOe_q;
  logic                 sclOe_q;
  logic                 apply_q;
  logic [1:0]           filt;
  logic [1:0]           prev_q;

  // ---------------------------------------------------------------
  // Input synchronisers and glitch filters, index 0 clock, 1 data
  // ---------------------------------------------------------------
  wire [1:0] rawIn = {bus.sda, bus.scl};
  for (genvar g = 0; g < 2; g++) begin : gFilt
    logic          s1_q;
    logic          s2_q;
    logic          f_q;
    logic [FW-1:0] cnt_q;
    always_ff @(posedge clk) begin
      if (!nrst) begin
        s1_q  <= 1'b1;
        s2_q  <= 1'b1;
        f_q   <= 1'b1;
        cnt_q <= '0;
      end else begin
        s1_q <= rawIn[g];
        s2_q <= s1_q;
        if (s2_q == f_q) begin
          cnt_q <= '0;
        end else if (cnt_q == FILT_LAST) begin // see R03
          f_q   <= s2_q;
          cnt_q <= '0;
        end else begin
          cnt_q <= cnt_q + FW'(1);
        end
      end
    end
    assign filt[g] = f_q;
  end

  // ---------------------------------------------------------------
  // Bus events and decode
  // ---------------------------------------------------------------
  wire sclRise   = filt[0] & ~prev_q[0];
  wire sclFall   = ~filt[0] & prev_q[0];
  wire sclHigh   = filt[0] & prev_q[0];
  wire startEv   = sclHigh & prev_q[1] & ~filt[1]; // see R04, R22
  wire stopEv    = sclHigh & ~prev_q[1] & filt[1]; // see R05
  wire lastBit   = bitCnt_q == 3'(BYTE_BITS - 1);
  wire addrHit   = shift_q[7:1] == SLAVE_ADDR; // see R18
  wire recvState = (st_q == D_ADDR) | (st_q == D_WRX);
  wire ptrOk     = ptr_q < 8'(NREG);
  wire [IW-1:0] ptrIdx = ptr_q[IW-1:0];
  wire [7:0] rdByte = ptrOk ? (dirty_q[ptrIdx] ? pend_q[ptrIdx] : act_q[ptrIdx]) : IDLE_BYTE;

  assign bus.sclSlvOut = 1'b0;
  assign bus.sdaSlvOut = 1'b0;
  assign bus.sclSlvOe  = sclOe_q;
  assign bus.sdaSlvOe  = sdaOe_q;
  assign cmdRegs       = act_q;
  assign cmdApply      = apply_q;

  // ---------------------------------------------------------------
  // Frame engine
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q      <= D_IDLE;
      bitCnt_q  <= '0;
      shift_q   <= '0;
      tx_q      <= '0;
      rw_q      <= RW_WRITE;
      addrAck_q <= 1'b0;
      phase_q   <= 1'b0;
      sdaOe_q   <= 1'b0;
      sclOe_q   <= 1'b0; // see R11
      prev_q    <= 2'b11;
    end else begin
      prev_q <= filt;
      if (startEv) begin // see R22
        st_q     <= D_START;
        bitCnt_q <= '0;
        sdaOe_q  <= 1'b0;
      end else if (stopEv) begin
        st_q    <= D_IDLE;
        sdaOe_q <= 1'b0;
      end else begin
        if (sclRise && recvState) begin
          shift_q <= {shift_q[6:0], filt[1]}; // see R08
        end
        if (sclFall) begin // see R01, R10
          unique case (st_q)
            D_ADDR, D_WRX: begin // see R07
              bitCnt_q <= bitCnt_q + 3'h1;
              if (lastBit) begin
                if (st_q == D_ADDR && !addrHit) begin
                  st_q <= D_IGNORE;
                end else begin
                  st_q      <= D_ACK;
                  sdaOe_q   <= 1'b1; // see R13, R15
                  addrAck_q <= st_q == D_ADDR;
                  if (st_q == D_ADDR) rw_q <= shift_q[0];
                end
              end
            end
            D_ACK: begin
              bitCnt_q <= '0;
              if (addrAck_q && rw_q == RW_READ) begin // see R12, R14
                st_q    <= D_TX;
                tx_q    <= rdByte;
                sdaOe_q <= ~rdByte[7];
              end else begin
                st_q    <= D_WRX;
                sdaOe_q <= 1'b0; // see R09
                phase_q <= addrAck_q ? 1'b0 : ~phase_q;
                if (!addrAck_q && !phase_q) ptr_q <= shift_q; // see R19
              end
            end
            D_TX: begin
              bitCnt_q <= bitCnt_q + 3'h1;
              if (lastBit) begin
                st_q    <= D_TXACK;
                sdaOe_q <= 1'b0; // see R16
              end else begin
                tx_q    <= {tx_q[6:0], 1'b1};
                sdaOe_q <= ~tx_q[6];
              end
            end
            D_TXACK: begin
              st_q    <= D_IGNORE; // see R17
              sdaOe_q <= 1'b0;
            end
            D_IDLE, D_IGNORE: begin
              sdaOe_q <= 1'b0; // see R20
            end
            D_START: begin
              st_q <= D_ADDR; // see R04
            end
          endcase
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Pending and active command bytes
  // ---------------------------------------------------------------
  wire storeData = sclFall & ~startEv & ~stopEv & (st_q == D_ACK) & ~addrAck_q & phase_q & ptrOk;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pend_q  <= '0;
      act_q   <= {NREG{CMD_RESET}};
      dirty_q <= '0;
      apply_q <= 1'b0;
    end else begin
      apply_q <= stopEv & (|dirty_q); // see R06
      for (int i = 0; i < NREG; i++) begin
        if (stopEv && dirty_q[i]) begin // see R21
          act_q[i]   <= pend_q[i];
          dirty_q[i] <= 1'b0;
        end
        if (storeData && ptrIdx == IW'(i)) begin // see R19
          pend_q[i]  <= shift_q;
          dirty_q[i] <= 1'b1;
        end
      end
    end
  end
endmodule // isc_slave
`default_nettype wire

//--- isc_props.sv
// Bus-side assertions for the two-wire command port.
`default_nettype none
module isc_props
  import isc_pkg::*;
#(
  parameter int QTR = SCL_QTR_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sda,
  input wire logic sclSlvOe,
  input wire logic sdaSlvOe,
  input wire logic sdaMstOe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // Frame tracking
  // ---------------------------------------------------------------
  localparam int DRV_MAX = 36 * QTR + 16;
  logic        scl_q;
  logic        sda_q;
  logic        match_q;
  logic        rd_q;
  logic [3:0]  cnt_q;
  logic [1:0]  byte_q;
  logic [7:0]  sh_q;
  logic [11:0] run_q;
  wire         rise     = scl & !scl_q;
  wire         startEv  = scl & scl_q & sda_q & !sda;
  wire         stopEv   = scl & scl_q & !sda_q & sda;
  wire         ninth    = rise & (cnt_q == 4'h8);
  wire  [7:0]  addrByte = {sh_q[6:0], sda};
  wire         ackSlot  = match_q & (cnt_q == 4'h8) & (!rd_q | (byte_q == 2'h0));
  wire         txSlot   = match_q & rd_q & (byte_q == 2'h1) & (cnt_q != 4'h8);
  always_ff @(posedge clk) begin
    scl_q <= scl;
    sda_q <= sda;
    sh_q  <= rise ? addrByte : sh_q;
    run_q <= sdaSlvOe ? run_q + 12'h001 : 12'h000;
    if (!nrst || startEv || stopEv) begin
      cnt_q   <= 4'h0;
      byte_q  <= 2'h0;
      match_q <= 1'b0;
      rd_q    <= 1'b0;
    end else if (rise) begin
      cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
      if (ninth && byte_q != 2'h2) byte_q <= byte_q + 2'h1;
      if (cnt_q == 4'h7 && byte_q == 2'h0) match_q <= (addrByte[7:1] == SLAVE_ADDR);
      if (cnt_q == 4'h7 && byte_q == 2'h0) rd_q <= addrByte[0];
    end
  end
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence addrNinth;
    rise && cnt_q == 4'h8 && byte_q == 2'h0;
  endsequence
  a_no_stretch: assert property (!sclSlvOe)
    else $error("slave pulled the clock line");
  a_no_contend: assert property (scl |-> !(sdaSlvOe && sdaMstOe))
    else $error("both ends drive data while clock high");
  a_steady_high: assert property (scl && $past(scl) |-> $stable(sdaSlvOe))
    else $error("slave changed data while clock high");
  a_wr_ack: assert property (ninth && match_q && !rd_q |-> sdaSlvOe)
    else $error("written byte not acknowledged");
  a_rd_addr_ack: assert property (addrNinth ##0 (match_q && rd_q) |-> sdaSlvOe)
    else $error("read address not acknowledged");
  a_addr_ignored: assert property (addrNinth ##0 !match_q |-> !sdaSlvOe)
    else $error("foreign address acknowledged");
  a_quiet_else: assert property (rise && !ackSlot && !txSlot |-> !sdaSlvOe)
    else $error("slave drove data outside its slots");
  a_drive_bounded: assert property (run_q <= DRV_MAX)
    else $error("slave held data low too long");
endmodule // isc_props
`default_nettype wire

//--- test_i2c_slave_command_port.sv
// Self-checking bench joining the command port to its bus master.
`default_nettype none
module test_i2c_slave_command_port
  import isc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int QTR   = 10;
  localparam int HQ    = 10;
  localparam int LIMIT = 90000;
  logic                     clk = 1'b0;
  logic                     nrst = 1'b0;
  logic                     cmdValid = 1'b0;
  logic                     cmdRead = 1'b0;
  logic [7:0]               cmdPtr = 8'h00;
  logic [7:0]               cmdData = 8'h00;
  logic                     sclPull = 1'b0;
  logic                     sdaPull = 1'b0;
  logic                     sel2 = 1'b0;
  logic                     cmdReady, rdValid, ackErr, busy, cmdApply, refused, ak;
  logic [7:0]               rdData, rb;
  logic [NUM_REGS-1:0][7:0] regs, regs2;
  logic [7:0]               rdq[$];
  int                       errors = 0, comparisons = 0, cyc = 0, acks = 0, applies = 0;
  isc_bus_if bus ();
  isc_bus_if bus2 ();
  assign bus2.sclMstOut = 1'b0;
  assign bus2.sdaMstOut = 1'b0;
  assign bus2.sclMstOe  = sclPull;
  assign bus2.sdaMstOe  = sdaPull;
  // The checker follows the bit-level bus once sel2 is raised.
  wire                      propScl   = sel2 ? bus2.scl : bus.scl;
  wire                      propSda   = sel2 ? bus2.sda : bus.sda;
  wire                      propSclOe = sel2 ? bus2.sclSlvOe : bus.sclSlvOe;
  wire                      propSdaOe = sel2 ? bus2.sdaSlvOe : bus.sdaSlvOe;
  wire                      propMstOe = sel2 ? bus2.sdaMstOe : bus.sdaMstOe;
  isc_master #(.QTR_CYC(QTR), .DEPTH(FIFO_DEPTH)) i_isc_master (.clk(clk), .nrst(nrst), .bus(bus.mst),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdRead(cmdRead), .cmdPtr(cmdPtr), .cmdData(cmdData),
    .rdValid(rdValid), .rdData(rdData), .ackErr(ackErr), .busy(busy));
  isc_slave #(.NREG(NUM_REGS), .FILT(FILT_CYC)) i_isc_slave (.clk(clk), .nrst(nrst), .bus(bus.slv),
    .cmdRegs(regs), .cmdApply(cmdApply));
  isc_slave #(.NREG(NUM_REGS), .FILT(FILT_CYC)) i_isc_slave2 (.clk(clk), .nrst(nrst), .bus(bus2.slv),
    .cmdRegs(regs2), .cmdApply());
  isc_props #(.QTR(QTR)) i_isc_props (.clk(clk), .nrst(nrst), .scl(propScl), .sda(propSda),
    .sclSlvOe(propSclOe), .sdaSlvOe(propSdaOe), .sdaMstOe(propMstOe));
  // ---------------------------------------------------------------
  // Clock, result capture and timeout
  // ---------------------------------------------------------------
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (rdValid === 1'b1) rdq.push_back(rdData);
    if (ackErr === 1'b1) acks++;
    if (cmdApply === 1'b1) applies++;
    if (cyc == LIMIT) begin
      errors++;
      finish_test();
    end
  end
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic finish_test();
    $display("counts: comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic send(input logic rd, input logic [7:0] p, input logic [7:0] d);
    cmdValid = 1'b1;
    cmdRead  = rd;
    cmdPtr   = p;
    cmdData  = d;
    while (cmdReady !== 1'b1) begin
      refused = 1'b1;
      tick(1);
    end
    tick(1);
  endtask
  task automatic drain();
    int n;
    n = 0;
    cmdValid = 1'b0;
    while (n < 60) begin
      tick(1);
      n = (busy === 1'b1) ? 0 : n + 1;
    end
  endtask
  task automatic bbStart();
    sdaPull = 1'b0;
    tick(HQ);
    sclPull = 1'b0;
    tick(HQ);
    sdaPull = 1'b1;
    tick(HQ);
    sclPull = 1'b1;
    tick(HQ);
  endtask
  task automatic bbStop();
    sdaPull = 1'b1;
    tick(HQ);
    sclPull = 1'b0;
    tick(HQ);
    sdaPull = 1'b0;
    tick(HQ);
  endtask
  task automatic bbBit(input logic b, input logic g, output logic r);
    sdaPull = !b;
    tick(HQ);
    sclPull = 1'b0;
    tick(HQ);
    if (g) begin
      sclPull = 1'b1;
      tick(1);
      sclPull = 1'b0;
      tick(HQ);
    end
    r = bus2.sda;
    tick(HQ);
    sclPull = 1'b1;
    tick(HQ);
  endtask
  task automatic bbByte(input logic [7:0] d, input logic g, input logic mAck, output logic [7:0] r,
                        output logic a);
    for (int i = 7; i >= 0; i--) bbBit(d[i], g && i == 3, r[i]);
    bbBit(!mAck, 1'b0, a);
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    refused = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    nrst = 1'b1;
    tick(4);
    for (int i = 0; i < NUM_REGS; i++) chk8(regs[i], CMD_RESET);
    $display("test reset done");
    send(1'b0, 8'h01, 8'hA5);
    send(1'b0, 8'h04, 8'h5A);
    send(1'b1, 8'h04, 8'h00);
    send(1'b1, 8'h07, 8'h00);
    drain();
    chk8(regs[1], 8'hA5);
    chk8(regs[4], 8'h5A);
    chk8(rdq[0], 8'h5A);
    chk8(rdq[1], IDLE_BYTE);
    chk8(8'(acks), 8'h00);
    chk8(8'(applies), 8'h02);
    $display("test write and read done");
    for (int i = 0; i < 34; i++) send(1'b0, 8'(i % 5), 8'(i));
    drain();
    chk8({7'h00, refused}, 8'h01);
    for (int p = 0; p < NUM_REGS; p++) chk8(regs[p], 8'(p == 4 ? 29 : 30 + p));
    $display("test queue fill done");
    bbStart();
    for (int i = 0; i < 4; i++) bbBit(1'b1, 1'b0, ak);
    bbStart();
    bbByte(8'hC8, 1'b1, 1'b0, rb, ak);
    chk8({7'h00, ak}, 8'h00);
    bbByte(8'h02, 1'b1, 1'b0, rb, ak);
    chk8({7'h00, ak}, 8'h00);
    bbByte(8'h77, 1'b0, 1'b0, rb, ak);
    chk8({7'h00, ak}, 8'h00);
    sel2 = 1'b1;
    bbStart();
    bbByte(8'hC9, 1'b0, 1'b0, rb, ak);
    chk8({7'h00, ak}, 8'h00);
    bbByte(8'hFF, 1'b0, 1'b1, rb, ak);
    chk8(rb, 8'h77);
    bbByte(8'hFF, 1'b0, 1'b0, rb, ak);
    chk8(rb, IDLE_BYTE);
    chk8(regs2[2], CMD_RESET);
    bbStop();
    tick(20);
    chk8(regs2[2], 8'h77);
    bbStart();
    bbByte(8'hA0, 1'b0, 1'b0, rb, ak);
    chk8({7'h00, ak}, 8'h01);
    bbStop();
    tick(20);
    $display("test bit level done");
    finish_test();
  end
endmodule // test_i2c_slave_command_port
`default_nettype wire
